// file: radio_irq_cfg.svh
`ifndef RADIO_IRQ_CFG_SVH
`define RADIO_IRQ_CFG_SVH

// Register addresses
`define ADDR_RADIO_CONTROL_ONE 6'h04
`define ADDR_IRQ_ENABLE_MASK   6'h0E
`define ADDR_IRQ_PENDING_FLAGS 6'h0F

// Reset values
`define RST_RADIO_CONTROL_ONE  8'h02
`define RST_IRQ_ENABLE_MASK    8'h00
`define RST_IRQ_PENDING_FLAGS  8'h00

// Control register fields
`define CTRL_POLARITY_BIT      0
`define CTRL_MASK_POLL_BIT     1

// Pending flag positions
`define IRQ_BIT_PLL_LOCK       0
`define IRQ_BIT_PLL_UNLOCK     1
`define IRQ_BIT_PAYLOAD_START  2
`define IRQ_BIT_FRAME_DONE     3
`define IRQ_BIT_WAKE_MEASURE   4
`define IRQ_BIT_ADDRESS_MATCH  5
`define IRQ_BIT_BUF_VIOLATION  6
`define IRQ_BIT_SUPPLY_LOW     7

`endif

// file: radio_irq_pkg.sv
package radio_irq_pkg;

    // Register-sized data word
    typedef logic [7:0] byte_type;

    // Register address width of the device
    typedef logic [5:0] reg_addr_type;

    // Which register an address selects
    typedef enum
    {
        SEL_NONE,
        SEL_CONTROL,
        SEL_MASK,
        SEL_PENDING
    } reg_sel_type;

endpackage

// file: irq_flag_if.sv
`timescale 1ns/100ps
interface irq_flag_if;
    import radio_irq_pkg::*;

    byte_type event_hit;    // One-cycle event pulses per flag
    byte_type record_en;    // Flags allowed to record
    byte_type cross_clear;  // Per-flag clear from the partner event
    logic     read_clear;   // Clearing read of the pending register
    byte_type pending;      // Latched flags

    modport owner
    (
        output event_hit,
        output record_en,
        output cross_clear,
        output read_clear,
        input  pending
    );

    modport latch
    (
        input  event_hit,
        input  record_en,
        input  cross_clear,
        input  read_clear,
        output pending
    );
endinterface

// file: irq_flag_latch.sv
`timescale 1ns/100ps
`include "radio_irq_cfg.svh"

module irq_flag_latch
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input wire logic  clk,
    input wire logic  rst_n,
    // Flag controls and state
    irq_flag_if.latch flags
);
    import radio_irq_pkg::*;

    // Reset image of the flags, one bit taken per flag below
    localparam logic [WIDTH-1:0] RST_FLAGS = WIDTH'(`RST_IRQ_PENDING_FLAGS);

    // One sticky flag per event_hit bit; a set in the clearing cycle survives
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_flag
            logic hit;
            assign hit = flags.event_hit[i] & flags.record_en[i];

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    flags.pending[i] <= RST_FLAGS[i];
                else if (hit)
                    flags.pending[i] <= 1'b1;
                else if (flags.read_clear || flags.cross_clear[i])
                    flags.pending[i] <= 1'b0;
            end
        end
    endgenerate
endmodule

// file: radio_irq_logic.sv
`timescale 1ns/100ps
`include "radio_irq_cfg.svh"

// Functional notes
// - Ten event sources share eight pending flags; flags 3 and 4 serve two each.
// - A source is enabled only when its mask bit is one; bit 7 supply, bit 0 lock.
// - Each pending event is latched in its flag; flags 3 and 4 each latch two sources.
// - Interrupt pin is the OR of enabled pending flags.
// - Reading the pending register returns flags then clears every flag not set in that same cycle, releasing the pin.
// - Flags are sticky; lock clears pending unlock and unlock clears pending lock.
// - Flag 7 marks low supply; flag 6 marks buffer access violation.
// - Flag 4 sets on wake-up completion and on channel measurement done.
// - Flag 3 sets on frame receive done and frame transmit done.
// - Flag 2 sets at payload start; state and length header come from outside.
// - Flag 1 marks lock loss and kills the amplifier when transmitting; flag 0 lock.
// - Flag 5 marks address match, latched like the others.
// - Mask resets to zero and accepts any byte value.
// - Without polling, masked events neither record nor signal.
// - With polling, all events record but only enabled ones drive the pin.
// - Pin is active high by default; polarity bit makes it active low.
// - During buffer reads with empty indication on, pin carries that indication.
// - Polling control is control bit 1, reset to one.
// - Polarity control is control bit 0, reset zero; one means active low.
// - Buffer empty indication is always active high.
module radio_irq_logic
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,

    // Register access from the serial engine
    input  wire radio_irq_pkg::reg_addr_type reg_addr,
    input  wire logic                     reg_wr_en,
    input  wire logic                     reg_rd_en,
    input  wire radio_irq_pkg::byte_type  reg_wdata,
    output radio_irq_pkg::byte_type       reg_rdata,

    // Radio event pulses
    input  wire logic                     supply_low_event,
    input  wire logic                     buffer_violation_event,
    input  wire logic                     address_match_event,
    input  wire logic                     wake_complete_event,
    input  wire logic                     channel_measure_done_event,
    input  wire logic                     frame_rx_done_event,
    input  wire logic                     frame_tx_done_event,
    input  wire logic                     payload_start_event,
    input  wire logic                     pll_unlock_event,
    input  wire logic                     pll_lock_event,

    // Radio state
    input  wire logic                     tx_busy,

    // Frame buffer empty indication
    input  wire logic                     fb_empty_enable,
    input  wire logic                     fb_read_active,
    input  wire logic                     fb_empty,

    // Outputs
    output logic                          irq_pin,
    output logic                          pa_shutdown,
    output radio_irq_pkg::byte_type       pending_flags,
    output radio_irq_pkg::byte_type       control_flags
);
    import radio_irq_pkg::*;

    // Register state
    byte_type radio_control_one_reg;
    byte_type interrupt_enable_mask_reg;
    byte_type reg_rdata_reg;
    logic     irq_pin_reg;
    logic     pa_shutdown_reg;

    // Next values
    byte_type reg_rdata_next;
    logic     irq_pin_next;

    // Decoded controls
    logic     polarity_low;
    logic     mask_poll;
    logic     any_enabled;
    logic     normal_pin;

    // Access decode
    reg_sel_type wr_sel;
    reg_sel_type rd_sel;
    logic        pending_read;

    // Event vector in flag order
    byte_type    event_vec;

    // Latch carrier
    irq_flag_if  flags ();

    // Address decode, shared by the write and read paths
    function automatic reg_sel_type decode(input reg_addr_type addr);
        reg_sel_type sel;
        sel = SEL_NONE;
        case (addr)
            `ADDR_RADIO_CONTROL_ONE: sel = SEL_CONTROL;
            `ADDR_IRQ_ENABLE_MASK:   sel = SEL_MASK;
            `ADDR_IRQ_PENDING_FLAGS: sel = SEL_PENDING;
            default:                 sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    // Write and read targets
    assign wr_sel = reg_wr_en ? decode(reg_addr) : SEL_NONE;
    assign rd_sel = reg_rd_en ? decode(reg_addr) : SEL_NONE;

    // A read of the pending register clears it
    assign pending_read = (rd_sel == SEL_PENDING);

    // Control fields
    assign polarity_low = radio_control_one_reg[`CTRL_POLARITY_BIT];
    assign mask_poll    = radio_control_one_reg[`CTRL_MASK_POLL_BIT];

    // Control register; other fields are kept for their owners
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            radio_control_one_reg <= `RST_RADIO_CONTROL_ONE;
        else if (wr_sel == SEL_CONTROL)
            radio_control_one_reg <= reg_wdata;
    end

    // Mask register, any byte accepted
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            interrupt_enable_mask_reg <= `RST_IRQ_ENABLE_MASK;
        else if (wr_sel == SEL_MASK)
            interrupt_enable_mask_reg <= reg_wdata;
    end

    // Pending register writes fall through with no effect;
    // only events and the clearing read move the flags.

    // Gather events into flag positions
    always_comb
    begin
        event_vec = '0;
        // Supply below threshold
        event_vec[`IRQ_BIT_SUPPLY_LOW] = supply_low_event;
        // Frame buffer access violation
        event_vec[`IRQ_BIT_BUF_VIOLATION] = buffer_violation_event;
        // Address match
        event_vec[`IRQ_BIT_ADDRESS_MATCH] = address_match_event;
        // Shared flag: wake-up done or measurement done
        event_vec[`IRQ_BIT_WAKE_MEASURE] = wake_complete_event
                                         | channel_measure_done_event;
        // Either direction of frame completion
        event_vec[`IRQ_BIT_FRAME_DONE] = frame_rx_done_event
                                       | frame_tx_done_event;
        // Payload reception starts
        event_vec[`IRQ_BIT_PAYLOAD_START] = payload_start_event;
        // Lock lost and lock gained
        event_vec[`IRQ_BIT_PLL_UNLOCK] = pll_unlock_event;
        event_vec[`IRQ_BIT_PLL_LOCK]   = pll_lock_event;
    end

    // Drive the latch; polling lets every source record
    assign flags.event_hit = event_vec;
    assign flags.record_en = mask_poll ? 8'hFF
                                       : interrupt_enable_mask_reg;
    assign flags.read_clear = pending_read;

    // Lock and unlock wipe each other even when not recorded
    always_comb
    begin
        flags.cross_clear = '0;
        flags.cross_clear[`IRQ_BIT_PLL_UNLOCK] = pll_lock_event;
        flags.cross_clear[`IRQ_BIT_PLL_LOCK]   = pll_unlock_event;
    end

    // Sticky flag store
    irq_flag_latch
    #(
        .WIDTH (8)
    )
    u_latch
    (
        .clk   (clk),
        .rst_n (rst_n),
        .flags (flags.latch)
    );

    // Pending flags exported for status monitoring
    assign pending_flags = flags.pending;
    assign control_flags = radio_control_one_reg;

    // Only enabled flags raise the pin; polled-only ones stay silent
    assign any_enabled = |(flags.pending & interrupt_enable_mask_reg);

    // Polarity applies to the normal function only
    assign normal_pin = polarity_low ? ~any_enabled : any_enabled;

    // Pin selection; the empty indication ignores polarity
    always_comb
    begin
        if (fb_empty_enable && fb_read_active)
            irq_pin_next = fb_empty;
        else
            irq_pin_next = normal_pin;
    end

    // Registered pin, so glitches from the OR never reach the host
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_pin_reg <= 1'b0;
        else
            irq_pin_reg <= irq_pin_next;
    end

    assign irq_pin = irq_pin_reg;

    // Amplifier off on lock loss while sending, one cycle pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pa_shutdown_reg <= 1'b0;
        else
            pa_shutdown_reg <= pll_unlock_event & tx_busy;
    end

    assign pa_shutdown = pa_shutdown_reg;

    // Read mux; unmapped addresses answer zero
    always_comb
    begin
        case (rd_sel)
            SEL_CONTROL: reg_rdata_next = radio_control_one_reg;
            SEL_MASK:    reg_rdata_next = interrupt_enable_mask_reg;
            SEL_PENDING: reg_rdata_next = flags.pending;
            SEL_NONE:    reg_rdata_next = reg_rdata_reg;
            default:     reg_rdata_next = 8'h00;
        endcase
        if (reg_rd_en && rd_sel == SEL_NONE)
            reg_rdata_next = 8'h00;
    end

    // Read data holds until the next read; the clear lands the same edge,
    // so the host always sees the flags as they were before clearing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_reg <= 8'h00;
        else
            reg_rdata_reg <= reg_rdata_next;
    end

    assign reg_rdata = reg_rdata_reg;

    // Host duties: flush stale flags before enabling, and read
    // the flags on every pin assertion; nothing here enforces it.
endmodule

// file: radio_irq_logic_sva.sv
`timescale 1ns/100ps
module radio_irq_checker
(
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         rst_n,
    // Register port
    input wire radio_irq_pkg::reg_addr_type  reg_addr,
    input wire logic                         reg_wr_en,
    input wire logic                         reg_rd_en,
    input wire radio_irq_pkg::byte_type      reg_wdata,
    input wire radio_irq_pkg::byte_type      reg_rdata,
    // Radio side
    input wire logic                         supply_low_event,
    input wire logic                         pll_unlock_event,
    input wire logic                         pll_lock_event,
    input wire logic                         tx_busy,
    input wire logic                         fb_empty_enable,
    input wire logic                         fb_read_active,
    input wire logic                         fb_empty,
    // Outputs
    input wire logic                         irq_pin,
    input wire logic                         pa_shutdown,
    input wire radio_irq_pkg::byte_type      pending_flags,
    input wire radio_irq_pkg::byte_type      control_flags
);
    import radio_irq_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Clearing read of the pending register
    sequence s_rd_pend;
        reg_rd_en && reg_addr == 6'h0F;
    endsequence

    a_read_data: assert property (s_rd_pend |=> reg_rdata == $past(pending_flags))
        else $error("read data differs from flags");
    a_read_clear: assert property (!supply_low_event ##0 s_rd_pend |=> !pending_flags[7])
        else $error("flag survived clearing read");
    a_set_wins: assert property (supply_low_event && control_flags[1] ##0 s_rd_pend |=> pending_flags[7])
        else $error("event lost in read cycle");
    a_lock_sets: assert property (pll_lock_event && control_flags[1] |=> pending_flags[0])
        else $error("lock flag not set");
    a_lock_clears: assert property (pll_lock_event && !pll_unlock_event |=> !pending_flags[1])
        else $error("lock did not clear unlock");
    // Only lock and unlock may drop a flag outside a read
    a_flags_sticky: assert property (!(reg_rd_en && reg_addr == 6'h0F)
        |=> ($past(pending_flags) & ~pending_flags & 8'hFC) == 8'h00)
        else $error("flag dropped without read");
    a_pa_kill: assert property (pll_unlock_event && tx_busy |=> pa_shutdown)
        else $error("amplifier not cut");
    a_pa_quiet: assert property (!(pll_unlock_event && tx_busy) |=> !pa_shutdown)
        else $error("amplifier cut without lock loss");
    a_pin_idle: assert property (pending_flags == 8'h00 && !(fb_empty_enable && fb_read_active)
        && !(reg_wr_en && reg_addr == 6'h04) |=> irq_pin == control_flags[0])
        else $error("pin active without flags");
    a_fb_override: assert property (fb_empty_enable && fb_read_active |=> irq_pin == $past(fb_empty))
        else $error("empty indication not on pin");
    a_ctrl_write: assert property (reg_wr_en && reg_addr == 6'h04 |=> control_flags == $past(reg_wdata))
        else $error("control write lost");
endmodule

bind radio_irq_logic radio_irq_checker u_radio_irq_checker (.*);

// file: host_model.sv
`timescale 1ns/100ps
module host_model
(
    // Clock and pin
    input wire logic                      clk,
    input wire logic                      irq_pin,
    // Register port
    input wire radio_irq_pkg::byte_type   reg_rdata,
    output radio_irq_pkg::reg_addr_type   reg_addr,
    output logic                          reg_wr_en,
    output logic                          reg_rd_en,
    output radio_irq_pkg::byte_type       reg_wdata
);
    import radio_irq_pkg::*;

    // Idle bus at time zero
    initial
    begin
        reg_addr = '0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_wdata = '0;
    end

    // One-cycle write strobe
    task automatic wr(input reg_addr_type a, input byte_type v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask

    // Data lands one cycle after the strobe
    task automatic rd(input reg_addr_type a, output byte_type v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Wait a bounded time for the pin, then fetch the sources
    task automatic service(input logic act, output byte_type v, output bit ok);
        int n;
        n = 0;
        while (irq_pin !== act && n < 8)
        begin
            @(posedge clk);
            #1 n++;
        end
        ok = (n < 8);
        rd(6'h0F, v);
    endtask
endmodule

// file: radio_irq_logic_bench.sv
`timescale 1ns/100ps
module radio_irq_logic_bench;
    import radio_irq_pkg::*;

    typedef struct {byte_type m; byte_type c; int e; byte_type f; logic p;} row_type;

    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [9:0]   ev = '0;
    logic         tx_busy = 1'b0;
    logic [2:0]   fb = '0;
    reg_addr_type reg_addr;
    logic         reg_wr_en;
    logic         reg_rd_en;
    byte_type     reg_wdata;
    byte_type     reg_rdata;
    byte_type     pending_flags;
    byte_type     control_flags;
    byte_type     d;
    logic         irq_pin;
    logic         pa_shutdown;
    bit           ok;
    int           fails = 0;
    int           total_checks = 0;
    // Mask, control, event, flags read, pin level
    row_type rows[12] = '{'{8'h80, 8'h00, 9, 8'h80, 1'b1}, '{8'h00, 8'h00, 8, 8'h00, 1'b0},
        '{8'h00, 8'h02, 8, 8'h40, 1'b0}, '{8'h20, 8'h02, 7, 8'h20, 1'b1},
        '{8'h10, 8'h00, 6, 8'h10, 1'b1}, '{8'h10, 8'h00, 5, 8'h10, 1'b1},
        '{8'h08, 8'h01, 4, 8'h08, 1'b0}, '{8'h08, 8'h00, 3, 8'h08, 1'b1},
        '{8'h04, 8'h00, 2, 8'h04, 1'b1}, '{8'h02, 8'h00, 1, 8'h02, 1'b1},
        '{8'h01, 8'h00, 0, 8'h01, 1'b1}, '{8'hFE, 8'h00, 0, 8'h00, 1'b0}};

    always #20 clk = ~clk;

    radio_irq_logic u_radio_irq_logic (.*, .supply_low_event(ev[9]), .buffer_violation_event(ev[8]),
        .address_match_event(ev[7]), .wake_complete_event(ev[6]), .channel_measure_done_event(ev[5]),
        .frame_rx_done_event(ev[4]), .frame_tx_done_event(ev[3]), .payload_start_event(ev[2]),
        .pll_unlock_event(ev[1]), .pll_lock_event(ev[0]), .fb_empty_enable(fb[2]),
        .fb_read_active(fb[1]), .fb_empty(fb[0]));
    host_model u_host_model (.*);

    task automatic chk(input byte_type s, input byte_type e);
        total_checks++;
        if (s !== e)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic pulse(input int e);
        @(posedge clk);
        ev <= 10'h001 << e;
        @(posedge clk);
        ev <= '0;
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // One event per row, pin then flags then release
        foreach (rows[i])
        begin
            u_host_model.wr(6'h0E, rows[i].m);
            u_host_model.wr(6'h04, rows[i].c);
            u_host_model.rd(6'h0F, d);
            pulse(rows[i].e);
            repeat (2) @(posedge clk);
            #1 chk({7'h00, irq_pin}, {7'h00, rows[i].p});
            u_host_model.service(rows[i].p, d, ok);
            // A pin that never came counts as a mismatch; the run goes on
            if (!ok)
            begin
                fails++;
            end
            chk(d, rows[i].f);
            repeat (2) @(posedge clk);
            #1 chk({7'h00, irq_pin}, {7'h00, rows[i].c[0]});
        end
        // Lock and unlock cancel each other
        u_host_model.wr(6'h04, 8'h02);
        pulse(0);
        pulse(1);
        u_host_model.rd(6'h0F, d);
        chk(d, 8'h02);
        pulse(1);
        pulse(0);
        u_host_model.rd(6'h0F, d);
        chk(d, 8'h01);
        // Event in the clearing read cycle must survive
        fork
            u_host_model.rd(6'h0F, d);
            pulse(9);
        join
        u_host_model.rd(6'h0F, d);
        chk(d, 8'h80);
        u_host_model.wr(6'h0F, 8'hFF);
        u_host_model.rd(6'h0F, d);
        chk(d, 8'h00);
        u_host_model.rd(6'h3F, d);
        chk(d, 8'h00);
        u_host_model.wr(6'h0E, 8'hFF);
        u_host_model.rd(6'h0E, d);
        chk(d, 8'hFF);
        // Lock loss while sending
        @(posedge clk);
        tx_busy <= 1'b1;
        pulse(1);
        #1 chk({7'h00, pa_shutdown}, 8'h01);
        @(posedge clk);
        #1 chk({7'h00, pa_shutdown}, 8'h00);
        // Empty indication stays active high under low polarity
        u_host_model.wr(6'h04, 8'h01);
        @(posedge clk);
        fb <= 3'b111;
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq_pin}, 8'h01);
        // Second reset in mid-run
        @(posedge clk);
        fb <= '0;
        tx_busy <= 1'b0;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(control_flags, 8'h02);
        chk(pending_flags, 8'h00);
        chk({7'h00, irq_pin}, 8'h00);
        chk({7'h00, pa_shutdown}, 8'h00);
        u_host_model.rd(6'h0E, d);
        chk(d, 8'h00);
        print_verdict();
    end
endmodule
